// >>> inc/fodi_regs.svh
// Register offsets, field positions and reset values of the flash
// operation-done interrupt logic. Assumes a 32-bit APB register bus.
`ifndef FODI_REGS_SVH
`define FODI_REGS_SVH

// ==================================================================
// Register byte offsets
`define FODI_OFS_FLAGS 12'h02C
`define FODI_OFS_FLAG_SET 12'h030
`define FODI_OFS_FLAG_CLEAR 12'h034
`define FODI_OFS_IRQ_ENABLE 12'h038

// ==================================================================
// Field positions and widths
`define FODI_BIT_ERASE 0
`define FODI_BIT_WRITE 1
`define FODI_NUM_SRC 2
`define FODI_ADDR_W 12

// ==================================================================
// Reset values
`define FODI_FLAGS_RST 2'h0
`define FODI_IEN_RST 2'h0

`endif

// >>> inc/fodi_pkg.sv
// Types shared by the flash operation-done interrupt logic.
// Assumes the offsets header is included where numbers are needed.
package fodi_pkg;

  // ================================================================
  // Decoded register write strobes travelling together
  typedef struct packed {
    logic       flag_set;
    logic       flag_clear;
    logic       irq_enable;
    logic [1:0] wdata;
  } fodi_wr_t;

  // ================================================================
  // APB access phases
  typedef enum logic [1:0] {
    FODI_IDLE,
    FODI_SETUP,
    FODI_ACCESS
  } fodi_phase_t;

endpackage : fodi_pkg

// >>> core/fodi_flag_bit.sv
// One sticky event flag with hardware set, software set and clear.
// Assumes single pclk domain; set strobes are single-cycle pulses.
module fodi_flag_bit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hw_set,
  input wire logic sw_set,
  input wire logic sw_clr,
  output logic flag_r
);

  // ================================================================
  // Sticky flag; any set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 1'b0;
    end else if (hw_set || sw_set) begin
      flag_r <= 1'b1;
    end else if (sw_clr) begin
      flag_r <= 1'b0;
    end
  end

endmodule : fodi_flag_bit

// >>> core/fodi_apb_decode.sv
// APB write decoder for the operation-done interrupt registers.
// Assumes an APB master obeying setup then access phases.
`include "fodi_regs.svh"
module fodi_apb_decode import fodi_pkg::*; (
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`FODI_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output fodi_wr_t wr
);

  // ================================================================
  // Write strobes, active only in the access phase
  logic wr_acc;
  assign wr_acc = psel && penable && pwrite;
  assign wr.flag_set = wr_acc && (paddr == `FODI_OFS_FLAG_SET);
  assign wr.flag_clear = wr_acc && (paddr == `FODI_OFS_FLAG_CLEAR);
  assign wr.irq_enable = wr_acc && (paddr == `FODI_OFS_IRQ_ENABLE);
  assign wr.wdata = pwdata[1:0];

endmodule : fodi_apb_decode

// >>> core/fodi_top.sv
// Operation-done interrupt flags of the flash controller, APB slave.
// Assumes write_done and erase_done are one-cycle pulses on pclk.
// Register map, byte offsets on the 12-bit address:
//   0x02C flags      read-only, bit 1 write done, bit 0 erase done
//   0x030 flag set   write one to set a flag, reads zero
//   0x034 flag clear write one to clear a flag, reads zero
//   0x038 enables    read-write, one enable per flag
// Any other address reads zero and ignores writes.
//
// Bus timing:
//   The slave answers with no wait states: pready is high in the
//   first access cycle, and read data was captured in the setup cycle.
//   pslverr is never raised.
//   A write lands at the edge that ends its access cycle; the flag or
//   enable shows one cycle later and the interrupt one cycle after that.
//   A done pulse and a clear in the same cycle leave the flag set, so
//   an event is never lost to a late clear.
`include "fodi_regs.svh"
module fodi_top import fodi_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`FODI_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic write_done,
  input wire logic erase_done,
  output logic irq_r
);

  // ================================================================
  // Register decode
  fodi_wr_t wr;
  logic [1:0] flags_r;
  logic [1:0] ien_r;
  logic [31:0] rdata_nxt;

  fodi_apb_decode u_dec (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .wr(wr)
  );

  // ================================================================
  // Sticky flags; writes to the flag register itself go nowhere
  fodi_flag_bit u_write_flag (
    .pclk(pclk),
    .presetn(presetn),
    .hw_set(write_done),
    .sw_set(wr.flag_set && wr.wdata[`FODI_BIT_WRITE]),
    .sw_clr(wr.flag_clear && wr.wdata[`FODI_BIT_WRITE]),
    .flag_r(flags_r[`FODI_BIT_WRITE])
  );

  fodi_flag_bit u_erase_flag (
    .pclk(pclk),
    .presetn(presetn),
    .hw_set(erase_done),
    .sw_set(wr.flag_set && wr.wdata[`FODI_BIT_ERASE]),
    .sw_clr(wr.flag_clear && wr.wdata[`FODI_BIT_ERASE]),
    .flag_r(flags_r[`FODI_BIT_ERASE])
  );

  // ================================================================
  // Interrupt enable register; upper write bits dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_r <= `FODI_IEN_RST;
    end else if (wr.irq_enable) begin
      ien_r <= wr.wdata;
    end
  end

  // ================================================================
  // Interrupt output from flags gated by enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(flags_r & ien_r);
    end
  end

  // ================================================================
  // Read mux; reserved bits and unmapped addresses read zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (paddr)
      `FODI_OFS_FLAGS: rdata_nxt = {30'h0000_0000, flags_r};
      `FODI_OFS_IRQ_ENABLE: rdata_nxt = {30'h0000_0000, ien_r};
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Read data registered in setup phase; answer in first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_nxt;
    end
  end

  // Zero wait states, no errors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
    end
  end

  // ================================================================
  // Bus phase tracker; remembers the phase of the previous cycle
  fodi_phase_t phase_r;
  fodi_phase_t phase_nxt;

  // Phase decoded from the request lines
  always_comb begin
    phase_nxt = FODI_IDLE;
    case ({psel, penable})
      2'h2: phase_nxt = FODI_SETUP;
      2'h3: phase_nxt = FODI_ACCESS;
      default: phase_nxt = FODI_IDLE;
    endcase
  end

  // Registered phase, used only by the checks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= FODI_IDLE;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // ================================================================
  // Checks on the flags
  // Hardware write done sets the write flag
  set_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    write_done |=> flags_r[`FODI_BIT_WRITE])
    else $error("write flag not set after write done");

  // Hardware erase done sets the erase flag
  set_erase_a: assert property (@(posedge pclk) disable iff (!presetn)
    erase_done |=> flags_r[`FODI_BIT_ERASE])
    else $error("erase flag not set after erase done");

  // Write flag stays until a clear
  flags_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (flags_r[1] && !wr.flag_clear) |=> flags_r[1])
    else $error("write flag lost without clear");

  // Erase flag stays until a clear
  erase_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (flags_r[0] && !wr.flag_clear) |=> flags_r[0])
    else $error("erase flag lost without clear");

  // Software set of the write flag
  write_swset_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr.flag_set && wr.wdata[1]) |=> flags_r[1])
    else $error("write flag not set by software");

  // Software set of the erase flag
  swset_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr.flag_set && wr.wdata[0]) |=> flags_r[0])
    else $error("erase flag not set by software");

  // Software clear of the write flag when no set competes
  swclr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr.flag_clear && wr.wdata[1] && !write_done && !(wr.flag_set && wr.wdata[1]))
      |=> !flags_r[1])
    else $error("write flag not cleared");

  // Software clear of the erase flag when no set competes
  erase_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr.flag_clear && wr.wdata[0] && !erase_done && !(wr.flag_set && wr.wdata[0]))
      |=> !flags_r[0])
    else $error("erase flag not cleared");

  // Write flag rises only from a set source
  write_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!flags_r[1] && !write_done && !(wr.flag_set && wr.wdata[1]))
      |=> !flags_r[1])
    else $error("write flag set without a source");

  // Erase flag rises only from a set source
  erase_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!flags_r[0] && !erase_done && !(wr.flag_set && wr.wdata[0]))
      |=> !flags_r[0])
    else $error("erase flag set without a source");

  // ================================================================
  // Checks on enables and the interrupt
  // Enable register takes the written bits
  ien_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr.irq_enable |=> ien_r == $past(pwdata[1:0]))
    else $error("enable register not updated");

  // Enable register keeps its value without a write
  ien_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr.irq_enable |=> $stable(ien_r))
    else $error("enable register changed without a write");

  // Interrupt follows flags and enables one cycle later
  irq_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 irq_r == |($past(flags_r) & $past(ien_r)))
    else $error("interrupt does not follow flags and enables");

  // Any enabled flag raises the interrupt
  irq_raise_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|(flags_r & ien_r)) |=> irq_r)
    else $error("interrupt not raised");

  // Write flag alone never raises the interrupt while disabled
  write_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!ien_r[1] && !(flags_r[0] && ien_r[0])) |=> !irq_r)
    else $error("disabled write flag raised the interrupt");

  // Erase flag alone never raises the interrupt while disabled
  erase_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!ien_r[0] && !(flags_r[1] && ien_r[1])) |=> !irq_r)
    else $error("disabled erase flag raised the interrupt");

  // ================================================================
  // Checks on the bus answer
  // Flag register read data
  rd_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == `FODI_OFS_FLAGS && !write_done
      && !erase_done) |=> prdata == {30'h0000_0000, flags_r})
    else $error("flag read data wrong");

  // Enable register read data, reserved bits zero
  rd_ien_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == `FODI_OFS_IRQ_ENABLE)
      |=> prdata == {30'h0000_0000, ien_r})
    else $error("enable read data wrong");

  // Every other address reads zero
  rd_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr != `FODI_OFS_FLAGS
      && paddr != `FODI_OFS_IRQ_ENABLE) |=> prdata == 32'h0000_0000)
    else $error("unread register not zero");

  // Ready follows every setup cycle
  ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready)
    else $error("no ready in access phase");

  // Ready only after a setup cycle
  ready_phase_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> phase_r == FODI_SETUP)
    else $error("ready without a setup cycle");

  // Ready stands for one cycle only
  ready_once_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held too long");

  // Read data held until the next read setup
  prdata_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data changed without a read");

  // The slave never signals an error
  no_error_a: assert property (@(posedge pclk) disable iff (!presetn)
    !pslverr)
    else $error("error response raised");

  // Main scenarios
  irq_cov_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq_r));
  clr_cov_c: cover property (@(posedge pclk) disable iff (!presetn) $fell(flags_r[0]));
  race_cov_c: cover property (@(posedge pclk) disable iff (!presetn)
    write_done && wr.flag_clear && wr.wdata[1]);
  back_to_back_c: cover property (@(posedge pclk) disable iff (!presetn)
    phase_r == FODI_ACCESS && psel && !penable);
  swset_irq_c: cover property (@(posedge pclk) disable iff (!presetn)
    (wr.flag_set && |(wr.wdata & ien_r)) ##2 irq_r);

endmodule : fodi_top

// >>> tb/tb_top.sv
// Self-checking bench for the flash operation-done interrupt flags.
// Assumes fodi_top with zero-wait APB and a registered interrupt output.
`include "fodi_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ==================================================================
  // Signals, counters and reference model state
  logic pclk, presetn, psel, penable, pwrite, write_done, erase_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, irq_r, err;
  int bad_count, total_checks;
  int flags_m, ien_m;
  logic [11:0] ofs [5] = '{`FODI_OFS_FLAGS, `FODI_OFS_FLAG_SET, `FODI_OFS_FLAG_CLEAR,
                           `FODI_OFS_IRQ_ENABLE, 12'h03C};

  fodi_top i_fodi_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .write_done(write_done), .erase_done(erase_done), .irq_r(irq_r));

  // ==================================================================
  // Clock generation
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ==================================================================
  // Verdict and tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) begin
      bad_count++;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // One-cycle completion pulses from the flash sequencer
  task automatic pulse(input logic [1:0] d);
    @(posedge pclk);
    write_done <= d[1];
    erase_done <= d[0];
    @(posedge pclk);
    write_done <= 1'b0;
    erase_done <= 1'b0;
  endtask : pulse

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_word

  task automatic chk_irq(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: irq got %b expected %b", $time, got, exp);
    end
  endtask : chk_irq

  // ==================================================================
  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge pclk);
    bad_count++;
    tally_and_finish();
  end

  // ==================================================================
  // Main sequence
  initial begin
    int d;
    {presetn, psel, penable, pwrite, write_done, erase_done} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    void'($urandom(32'he2e2));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values of every register plus one unmapped word
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ofs[i], 32'h0000_0000);
      chk_word(rd, 32'h0000_0000, "reset read");
    end
    $display("test reset values done");
    // Every access kind and event, in turn, with random two-bit data
    for (int i = 0; i < 60; i++) begin
      d = $urandom % 4;
      case (i % 5)
        0: begin
          apb(1'b1, `FODI_OFS_FLAG_SET, d);
          flags_m |= d;
        end
        1: begin
          apb(1'b1, `FODI_OFS_FLAG_CLEAR, d);
          flags_m &= ~d;
        end
        2: begin
          apb(1'b1, `FODI_OFS_IRQ_ENABLE, d);
          ien_m = d;
        end
        3: apb(1'b1, `FODI_OFS_FLAGS, d);
        default: begin
          pulse(d[1:0]);
          flags_m |= d;
        end
      endcase
      repeat (2) @(posedge pclk);
      #1;
      chk_irq(irq_r, (flags_m & ien_m) != 0);
      apb(1'b0, `FODI_OFS_FLAGS, 32'h0000_0000);
      chk_word(rd, flags_m, "flags");
      apb(1'b0, `FODI_OFS_IRQ_ENABLE, 32'h0000_0000);
      chk_word(rd, ien_m, "enable");
      chk_word({31'h0000_0000, err}, 32'h0000_0000, "error response");
    end
    $display("test random access done");
    // Hardware done and software clear at the same edge: the set wins
    pulse(2'h3);
    fork
      apb(1'b1, `FODI_OFS_FLAG_CLEAR, 32'h0000_0003);
      begin
        @(posedge pclk);
        pulse(2'h3);
      end
    join
    flags_m = 3;
    apb(1'b0, `FODI_OFS_FLAGS, 32'h0000_0000);
    chk_word(rd, flags_m, "flags after race");
    $display("test set against clear done");
    // Reset again in mid-run with flags and enables set
    apb(1'b1, `FODI_OFS_IRQ_ENABLE, 32'h0000_0003);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    chk_irq(irq_r, 1'b0);
    @(posedge pclk);
    presetn <= 1'b1;
    flags_m = 0;
    ien_m = 0;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ofs[i], 32'h0000_0000);
      chk_word(rd, 32'h0000_0000, "read after reset");
    end
    $display("test mid-run reset done");
    tally_and_finish();
  end
endmodule : tb_top
